//--- src/sem_cyclic_master.sv
// Cyclic clock master for an absolute position encoder on a synchronous serial line,
// with an AXI4-Lite register slave and one level interrupt.
// Assumes core_clk at 250 MHz; the encoder data pin is asynchronous to it.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sem_regs.svh"

// Contract
// - Clock 1 Mbps, both lines idle high
// - Decode binary or Gray, Gray by default
// - Start a read every N x 125 us
// - Multi-turn count 0 to 14, reject more
// - Line check adds one clock after data
// - Line check sampled high flags wire break
// - Mode 0000h line check, 0001h data only
// - Parity modes check odd or even parity
// - Free-bit modes clock extra bits unevaluated
// - Reserved mode values are never accepted
// - Multi-turn disable is negative logic, default used; the code disables on a 1 in bit 2 and reads multi-turn as 0
module sem_cyclic_master #(
    parameter int unsigned PERIOD_CYCLES = `SEM_PERIOD_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             ssi_clk_o,
    input  wire logic        ssi_data_i,
    output logic             irq
);

    localparam logic [7:0]  HALF = 8'(`SEM_HALF_BIT_CYC);
    localparam logic [10:0] MONO = 11'(`SEM_MONO_CYC);

    // Gray to binary over the whole received word, aligned at bit 0.
    function automatic logic [47:0] gray2bin(input logic [47:0] g);
        logic [47:0] b;
        b = g;
        for (int i = 46; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : gray2bin

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[8*i +: 8] = n[8*i +: 8];
        end
        return r;
    endfunction : merge

    // Registers and state.
    logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0]  wstrb_q;
    logic [1:0]  bresp_q, rresp_q;
    logic        enable_q, code_gray_q, mt_disable_n_q;
    logic [3:0]  mt_count_q;
    logic [4:0]  st_count_q;
    logic [15:0] mode_q, period_mult_q, mult_cnt_q;
    logic [31:0] pos_single_q, pos_multi_q;
    logic [`SEM_ST_WIDTH-1:0] status_q, mask_q;
    logic        data_s1_q, data_s2_q, clk_q, done_q, par_bit_q, wb_bit_q;
    sem_pkg::sem_state_t state_q;
    logic [7:0]  half_cnt_q;
    logic [10:0] mono_cnt_q;
    logic [19:0] base_cnt_q;
    logic [5:0]  idx_q, ndata_q, total_q;
    logic [3:0]  f_mt_q;
    logic [4:0]  f_st_q;
    sem_pkg::sem_trail_t trail_q;
    logic [47:0] data_q;

    // Bus decode and write-side field checks.
    wire        wr_fire  = aw_hold_q && w_hold_q && !bvalid_q;
    wire [31:0] wr_old   = (awaddr_q == `SEM_OFF_CONFIG) ?
                           {19'h0, st_count_q, mt_count_q, 1'b0, mt_disable_n_q,
                            code_gray_q, enable_q} :
                           (awaddr_q == `SEM_OFF_MODE) ? {16'h0, mode_q} :
                           (awaddr_q == `SEM_OFF_PERIOD) ? {16'h0, period_mult_q} :
                           (awaddr_q == `SEM_OFF_STATUS) ? 32'h0 : // Unwritten lanes clear nothing.
                           {28'h0, mask_q};
    wire [31:0] wr_new   = merge(wr_old, wdata_q, wstrb_q);
    wire        wr_cfg   = wr_fire && awaddr_q == `SEM_OFF_CONFIG;
    wire        wr_mode  = wr_fire && awaddr_q == `SEM_OFF_MODE;
    wire        wr_per   = wr_fire && awaddr_q == `SEM_OFF_PERIOD;
    wire        wr_mask  = wr_fire && awaddr_q == `SEM_OFF_IRQ_MASK;
    wire        wr_stat  = wr_fire && awaddr_q == `SEM_OFF_STATUS;
    wire        wr_map   = wr_cfg | wr_mode | wr_per | wr_mask | wr_stat;
    wire [3:0]  new_mt   = wr_new[`SEM_CFG_MT_MSB:`SEM_CFG_MT_LSB];
    wire [4:0]  new_st   = wr_new[`SEM_CFG_ST_MSB:`SEM_CFG_ST_LSB];
    wire        mt_bad   = new_mt > `SEM_MT_MAX;
    wire        st_bad   = new_st == 5'h0;
    sem_pkg::sem_trail_t wr_trail;
    assign wr_trail = sem_pkg::mode_decode(wr_new[15:0]);
    wire        mode_bad = !wr_trail.valid;
    wire        per_bad  = wr_new[15:0] == 16'h0;
    wire        reject   = (wr_cfg && (mt_bad || st_bad)) || (wr_mode && mode_bad) ||
                           (wr_per && per_bad);
    wire [31:0] rd_mux   = (s_axi_araddr == `SEM_OFF_CONFIG) ?
                           {19'h0, st_count_q, mt_count_q, 1'b0, mt_disable_n_q,
                            code_gray_q, enable_q} :
                           (s_axi_araddr == `SEM_OFF_MODE) ? {16'h0, mode_q} :
                           (s_axi_araddr == `SEM_OFF_PERIOD) ? {16'h0, period_mult_q} :
                           (s_axi_araddr == `SEM_OFF_POS_SINGLE) ? pos_single_q :
                           (s_axi_araddr == `SEM_OFF_POS_MULTI) ? pos_multi_q :
                           (s_axi_araddr == `SEM_OFF_STATUS) ? {28'h0, status_q} :
                           (s_axi_araddr == `SEM_OFF_IRQ_MASK) ? {28'h0, mask_q} : 32'h0;
    wire        rd_map   = s_axi_araddr <= `SEM_OFF_IRQ_MASK && s_axi_araddr[1:0] == 2'b00;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Address and data are caught independently; the response waits for both.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_hold_q <= 1'b0; w_hold_q <= 1'b0; bvalid_q <= 1'b0; rvalid_q <= 1'b0;
            awaddr_q <= 8'h0; wdata_q <= 32'h0; wstrb_q <= 4'h0; rdata_q <= 32'h0;
            bresp_q <= 2'b00; rresp_q <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wr_map && !reject) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= rd_map ? 2'b00 : 2'b10;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Configuration registers; a rejected field keeps its old value.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            enable_q <= 1'b0; code_gray_q <= `SEM_RST_CODE; mt_disable_n_q <= 1'b0;
            mt_count_q <= `SEM_RST_MT; st_count_q <= `SEM_RST_ST;
            mode_q <= `SEM_RST_MODE; period_mult_q <= `SEM_RST_PERIOD;
            mask_q <= '0;
        end else begin
            if (wr_cfg) begin
                enable_q       <= wr_new[`SEM_CFG_ENABLE_BIT];
                code_gray_q    <= wr_new[`SEM_CFG_CODE_BIT];
                mt_disable_n_q <= wr_new[`SEM_CFG_MTDIS_BIT];
                if (!mt_bad) mt_count_q <= new_mt;
                if (!st_bad) st_count_q <= new_st;
            end
            if (wr_mode && !mode_bad) mode_q <= wr_new[15:0];
            if (wr_per && !per_bad) period_mult_q <= wr_new[15:0];
            if (wr_mask) mask_q <= wr_new[`SEM_ST_WIDTH-1:0];
        end
    end

    // Period base of 125 us and the multiplier on top of it.
    wire tick  = base_cnt_q == 20'(PERIOD_CYCLES - 1);
    wire hit   = mult_cnt_q >= period_mult_q - 16'h1;
    wire start = enable_q && tick && hit && state_q == sem_pkg::SEM_IDLE;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            base_cnt_q <= 20'h0;
            mult_cnt_q <= 16'h0;
        end else if (!enable_q) begin
            base_cnt_q <= 20'h0;
            mult_cnt_q <= 16'h0;
        end else begin
            base_cnt_q <= tick ? 20'h0 : base_cnt_q + 20'h1;
            if (tick) mult_cnt_q <= hit ? 16'h0 : mult_cnt_q + 16'h1;
        end
    end

    // The data pin is asynchronous; only the second stage is read by logic.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_s1_q <= 1'b1;
            data_s2_q <= 1'b1;
        end else begin
            data_s1_q <= ssi_data_i;
            data_s2_q <= data_s1_q;
        end
    end

    // Bit phases: each period is a low half then a high half, sampled at its end.
    wire half_end  = half_cnt_q == HALF - 8'h1;
    wire sample    = state_q == sem_pkg::SEM_SHIFT && half_end && clk_q;
    wire last_bit  = idx_q == total_q - 6'h1;
    wire [5:0] par_idx = ndata_q + 6'(trail_q.nfree);
    wire [5:0] ndata_w = 6'(mt_count_q) + 6'(st_count_q);
    sem_pkg::sem_trail_t trail_w;
    assign trail_w = sem_pkg::mode_decode(mode_q);

    // Frame sequencer; frame shape is frozen at the start so writes cannot tear it.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= sem_pkg::SEM_IDLE; clk_q <= 1'b1; half_cnt_q <= 8'h0;
            mono_cnt_q <= 11'h0; idx_q <= 6'h0; ndata_q <= 6'h0; total_q <= 6'h0;
            f_mt_q <= 4'h0; f_st_q <= 5'h0; trail_q <= '0; data_q <= 48'h0;
            par_bit_q <= 1'b0; wb_bit_q <= 1'b0; done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                sem_pkg::SEM_IDLE: begin
                    clk_q <= 1'b1;
                    if (start) begin
                        state_q    <= sem_pkg::SEM_SHIFT;
                        clk_q      <= 1'b0;
                        half_cnt_q <= 8'h0;
                        idx_q      <= 6'h0;
                        data_q     <= 48'h0;
                        ndata_q    <= ndata_w;
                        f_mt_q     <= mt_count_q;
                        f_st_q     <= st_count_q;
                        trail_q    <= trail_w;
                        total_q    <= ndata_w + 6'(trail_w.nfree) + 6'(trail_w.par_en)
                                      + 6'(trail_w.wb_en);
                    end
                end
                sem_pkg::SEM_SHIFT: begin
                    half_cnt_q <= half_end ? 8'h0 : half_cnt_q + 8'h1;
                    if (half_end && !clk_q) clk_q <= 1'b1;
                    if (sample) begin
                        if (idx_q < ndata_q) data_q <= {data_q[46:0], data_s2_q};
                        if (trail_q.par_en && idx_q == par_idx) par_bit_q <= data_s2_q;
                        if (trail_q.wb_en && last_bit) wb_bit_q <= data_s2_q;
                        if (last_bit) begin
                            state_q    <= sem_pkg::SEM_MONO;
                            mono_cnt_q <= 11'h0;
                            done_q     <= 1'b1;
                        end else begin
                            clk_q <= 1'b0;
                            idx_q <= idx_q + 6'h1;
                        end
                    end
                end
                sem_pkg::SEM_MONO: begin
                    mono_cnt_q <= mono_cnt_q + 11'h1;
                    if (mono_cnt_q == MONO - 11'h1) state_q <= sem_pkg::SEM_IDLE;
                end
                default: state_q <= sem_pkg::SEM_IDLE;
            endcase
        end
    end

    assign ssi_clk_o = clk_q;

    // Decode and split the word; parity covers the raw data bits.
    wire [47:0] dec_w    = code_gray_q ? gray2bin(data_q) : data_q;
    wire [47:0] st_mask  = ~(48'hffff_ffff_ffff << f_st_q);
    wire [47:0] mt_mask  = ~(48'hffff_ffff_ffff << f_mt_q);
    wire [47:0] mt_val   = (dec_w >> f_st_q) & mt_mask;
    wire        par_fail = trail_q.par_en && ((^data_q ^ par_bit_q) != trail_q.par_odd);
    wire        wb_fail  = trail_q.wb_en && wb_bit_q;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pos_single_q <= 32'h0;
            pos_multi_q  <= 32'h0;
        end else if (done_q) begin
            pos_single_q <= 32'(dec_w & st_mask);
            pos_multi_q  <= mt_disable_n_q ? 32'h0 : 32'(mt_val);
        end
    end

    // Sticky status; an event in the clearing cycle wins over the clear.
    wire [`SEM_ST_WIDTH-1:0] ev = {reject, done_q && par_fail, done_q && wb_fail, done_q};
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~(wr_stat ? wr_new[`SEM_ST_WIDTH-1:0] : '0)) | ev;
        end
    end

    assign irq = |(status_q & mask_q);

    // Checks on the frame sequencer and flags.
    logic [5:0] fall_cnt_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) fall_cnt_q <= 6'h0;
        else if (start) fall_cnt_q <= 6'h1;
        else if (state_q == sem_pkg::SEM_SHIFT && half_end && clk_q && !last_bit)
            fall_cnt_q <= fall_cnt_q + 6'h1;
    end

    // Ticks since the last start, counted apart from the multiplier so that a broken
    // multiplier cannot hide behind its own count.
    logic [15:0] tick_cnt_q;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) tick_cnt_q <= 16'h0;
        else if (start) tick_cnt_q <= 16'h0;
        else if (tick && tick_cnt_q != 16'hffff) tick_cnt_q <= tick_cnt_q + 16'h1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_idle_high;
        state_q != sem_pkg::SEM_SHIFT |-> ssi_clk_o;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("Clock not high at rest.");
    property p_low_half;
        $fell(ssi_clk_o) |-> ##125 $rose(ssi_clk_o);
    endproperty
    a_low_half: assert property (p_low_half) else $error("Low half not 500 ns.");
    property p_start_period;
        start |-> tick && (17'(tick_cnt_q) + 17'h1 >= 17'(period_mult_q));
    endproperty
    a_start_period: assert property (p_start_period) else $error("Start off period.");
    property p_frame_len;
        done_q |-> fall_cnt_q == total_q;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("Wrong clock count.");
    property p_wire_break;
        done_q && trail_q.wb_en && wb_bit_q |=> status_q[`SEM_ST_WIRE_BREAK];
    endproperty
    a_wire_break: assert property (p_wire_break) else $error("Wire break missed.");
    property p_parity;
        done_q && par_fail |=> status_q[`SEM_ST_PARITY_ERR];
    endproperty
    a_parity: assert property (p_parity) else $error("Parity error missed.");
    property p_mt_reject;
        wr_cfg && mt_bad |=> mt_count_q == $past(mt_count_q) && status_q[`SEM_ST_CFG_REJECT];
    endproperty
    a_mt_reject: assert property (p_mt_reject) else $error("Large count taken.");
    property p_mode_legal;
        trail_w.valid;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("Reserved mode held.");
    property p_mt_off;
        done_q && mt_disable_n_q |=> pos_multi_q == 32'h0;
    endproperty
    a_mt_off: assert property (p_mt_off) else $error("Multi-turn not cleared.");

    c_frame: cover property (done_q);
    c_wire_break: cover property (done_q && wb_fail);
    c_parity_err: cover property (done_q && par_fail);
    c_irq: cover property ($rose(irq));

endmodule : sem_cyclic_master
`default_nettype wire

//--- src/sem_regs.svh
// Register map, field positions, reset values and timing counts of the cyclic serial
// encoder clock master. Assumes a 250 MHz core clock and a 32-bit AXI4-Lite slave port.
`ifndef SEM_REGS_SVH
`define SEM_REGS_SVH

// Byte offsets of the registers.
`define SEM_OFF_CONFIG      8'h00
`define SEM_OFF_MODE        8'h04
`define SEM_OFF_PERIOD      8'h08
`define SEM_OFF_POS_SINGLE  8'h0c
`define SEM_OFF_POS_MULTI   8'h10
`define SEM_OFF_STATUS      8'h14
`define SEM_OFF_IRQ_MASK    8'h18

// Fields of the configuration register.
`define SEM_CFG_ENABLE_BIT  0
`define SEM_CFG_CODE_BIT    1
`define SEM_CFG_MTDIS_BIT   2
`define SEM_CFG_MT_LSB      4
`define SEM_CFG_MT_MSB      7
`define SEM_CFG_ST_LSB      8
`define SEM_CFG_ST_MSB      12

// Status bits, shared by the mask register.
`define SEM_ST_FRAME_DONE   0
`define SEM_ST_WIRE_BREAK   1
`define SEM_ST_PARITY_ERR   2
`define SEM_ST_CFG_REJECT   3
`define SEM_ST_WIDTH        4

// Reset values and the multi-turn count limit.
`define SEM_RST_CODE        1'b1
`define SEM_RST_MT          4'hc
`define SEM_RST_ST          5'h0d
`define SEM_RST_MODE        16'h0000
`define SEM_RST_PERIOD      16'h0001
`define SEM_MT_MAX          4'he

// Timing: core clock, serial bit rate, read period base and monoflop hold-off.
`define SEM_CLK_MHZ         250
`define SEM_BIT_RATE_KBPS   1000
`define SEM_HALF_BIT_CYC    ((`SEM_CLK_MHZ * 1000) / (`SEM_BIT_RATE_KBPS * 2))
`define SEM_PERIOD_US       125
`define SEM_PERIOD_CYC      (`SEM_PERIOD_US * `SEM_CLK_MHZ)
`define SEM_MONO_NS         6000
`define SEM_MONO_CYC        ((`SEM_MONO_NS * `SEM_CLK_MHZ + 999) / 1000)

`endif

//--- src/sem_pkg.sv
// Types and the trailing-bit mode decoder of the cyclic serial encoder clock master.
// Assumes nothing of its surroundings.
package sem_pkg;

    // Frame states, Gray coded along idle, shift, monoflop hold-off.
    typedef enum logic [1:0] {
        SEM_IDLE  = 2'b00,
        SEM_SHIFT = 2'b01,
        SEM_MONO  = 2'b11
    } sem_state_t;

    // Trailing bits after the data: free bits, then parity, then line check.
    typedef struct packed {
        logic       valid;
        logic [2:0] nfree;
        logic       par_en;
        logic       par_odd;
        logic       wb_en;
    } sem_trail_t;

    // Decodes a trailing-bit mode; any value not listed comes back invalid.
    function automatic sem_trail_t mode_decode(input logic [15:0] m);
        sem_trail_t t;
        t = '{valid: 1'b1, nfree: 3'h0, par_en: 1'b0, par_odd: 1'b0, wb_en: 1'b0};
        case (m)
            16'h0000: t.wb_en = 1'b1;
            16'h0001: t.valid = 1'b1;
            16'h0002: t = '{1'b1, 3'h0, 1'b1, 1'b1, 1'b1};
            16'h0003: t = '{1'b1, 3'h1, 1'b1, 1'b1, 1'b1};
            16'h0004: t = '{1'b1, 3'h0, 1'b1, 1'b1, 1'b0};
            16'h0005: t = '{1'b1, 3'h1, 1'b1, 1'b1, 1'b0};
            16'h0006: t = '{1'b1, 3'h1, 1'b0, 1'b0, 1'b1};
            16'h0007: t = '{1'b1, 3'h2, 1'b0, 1'b0, 1'b1};
            16'h000c: t = '{1'b1, 3'h0, 1'b1, 1'b0, 1'b1};
            16'h000d: t = '{1'b1, 3'h1, 1'b1, 1'b0, 1'b1};
            16'h000e: t = '{1'b1, 3'h0, 1'b1, 1'b0, 1'b0};
            16'h000f: t = '{1'b1, 3'h1, 1'b1, 1'b0, 1'b0};
            16'h001f: t.nfree = 3'h1;
            16'h0020: t.nfree = 3'h2;
            16'h0021: t.nfree = 3'h3;
            16'h0022: t.nfree = 3'h4;
            default:  t.valid = 1'b0;
        endcase
        return t;
    endfunction : mode_decode

endpackage : sem_pkg

//--- dv/sem_enc_model.sv
// Behavioural absolute encoder on the far side of the serial link.
// Assumes the master rests its clock high between frames.
`timescale 1ns/10ps
`default_nettype none
module sem_enc_model (
    input  wire logic        sclk,
    input  wire logic [31:0] word,
    input  wire logic [5:0]  nb,
    input  wire logic        brk,
    output var  logic        sdo
);
    logic [31:0] sh;
    logic        idle;
    int          n;
    time         tr;
    // Start at rest with the data line high.
    initial begin
        idle = 1'b1;
        sdo  = 1'b1;
        n    = 0;
        tr   = 0;
    end
    // The word is captured at the first falling edge; its first bit goes out at the next rising edge.
    always @(negedge sclk) if (idle) begin
        sh   = word;
        n    = 0;
        idle = 1'b0;
    end
    // Bits leave MSB first; past the word the line is driven low, an open line reads high.
    always @(posedge sclk) if (!idle) begin
        tr  = $time;
        sdo = brk | (n < nb ? sh[nb-1-n] : 1'b0);
        n++;
    end
    // The monoflop ends about 6.2 us after the last rise, just over the 6 us minimum.
    always #100 if (!idle && sclk && $time - tr > 6200) begin
        idle = 1'b1;
        sdo  = 1'b1;
    end
endmodule : sem_enc_model
`default_nettype wire

//--- dv/ssi_encoder_cyclic_master_test.sv
// Self-checking bench of the cyclic serial encoder clock master.
// Assumes the encoder model and a base period shortened to 4050 cycles.
`timescale 1ns/10ps
`default_nettype none
module ssi_encoder_cyclic_master_test;
    localparam int PC = 4050;
    localparam logic [15:0] MD [16] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
        16'h0005, 16'h0006, 16'h0007, 16'h000c, 16'h000d, 16'h000e, 16'h000f, 16'h001f,
        16'h0020, 16'h0021, 16'h0022};
    localparam int EX [16] = '{1, 0, 2, 3, 1, 2, 2, 3, 2, 3, 1, 2, 1, 2, 3, 4};
    logic        core_clk, sys_rst, awv, wv, bry, arv, rry, brk, awr, wrdy, bv, arr, rv;
    logic        sck, sdi, irq, pv;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdt, mw, r32;
    logic [1:0]  br, rr;
    logic [5:0]  mn;
    int          mismatches, cmp_count, cyc, hi, lo, lol, nf, t0, gap, i;
    sem_cyclic_master #(.PERIOD_CYCLES(PC)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .ssi_clk_o(sck), .ssi_data_i(sdi), .irq(irq));
    sem_enc_model enc (.sclk(sck), .word(mw), .nb(mn), .brk(brk), .sdo(sdi));
    // Free-running core clock.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Each channel is released at its own handshake edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge core_clk);
        awa <= a;
        wd  <= d;
        awv <= 1'b1;
        wv  <= 1'b1;
        bry <= 1'b1;
        for (int k = 0; k < 50 && !bv; k++) begin
            @(posedge core_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
        end
        bry <= 1'b0;
        chk({bv, br}, {1'b1, e});
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
        @(posedge core_clk);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        for (int k = 0; k < 50 && !rv; k++) begin
            @(posedge core_clk);
            if (arv && arr) arv <= 1'b0;
        end
        rry <= 1'b0;
        d = rdt;
        chk({rv, rr}, {1'b1, e});
    endtask : rd
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v, 2'b00);
        chk(v, e);
    endtask : rdc
    // Clears status, then polls until a frame completes; r32 keeps its status.
    task automatic frm;
        wr(8'h14, 32'hf, 2'b00);
        for (int k = 0; k < 5000; k++) begin
            rd(8'h14, r32, 2'b00);
            if (r32[0]) break;
        end
        chk(r32[0], 1'b1);
    endtask : frm
    // Link monitor: clock halves, falls per frame, start-to-start gap, plus the timeout.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        pv  <= sck;
        hi  <= sck ? hi + 1 : 0;
        lo  <= sck ? 0 : lo + 1;
        if (sck && !pv) lol <= lo;
        if (pv && !sck) nf <= (hi > 400) ? 1 : nf + 1;
        if (pv && !sck && hi > 400) t0 <= cyc;
        if (pv && !sck && hi > 400) gap <= cyc - t0;
        if (cyc == 120000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        {sys_rst, awv, wv, bry, arv, rry, brk, pv} = 8'h01 << 7;
        {awa, ara, wd, mw, cyc, hi, lo, lol, nf, t0, gap, mismatches, cmp_count} = '0;
        mn = 6'h06;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk(sck, 1'b1);
        rdc(8'h00, 32'h0dc2);
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'h1);
        wr(8'h00, 32'h0df2, 2'b10);
        wr(8'h04, 32'h0008, 2'b10);
        wr(8'h04, 32'h0023, 2'b10);
        rdc(8'h14, 32'h8);
        rdc(8'h00, 32'h0dc2);
        rd(8'h1c, r32, 2'b10);
        chk(r32, 32'h0);
        $display("test registers done");
        mw <= 32'h2d;
        wr(8'h00, 32'h0421, 2'b00);
        // The default-mode frame also checks the split word and an intact line.
        for (i = 0; i < 16; i++) begin
            wr(8'h04, {16'h0, MD[i]}, 2'b00);
            frm();
            chk(nf, 6 + EX[i]);
            if (i == 0) begin
                rdc(8'h10, 32'h2);
                rdc(8'h0c, 32'hd);
                chk(lol, 125);
                chk(r32[1], 1'b0);
            end
        end
        $display("test trailing modes done");
        for (i = 0; i < 4; i++) begin
            mw <= {25'h0, 6'h2d, i == 0 || i == 3};
            mn <= 6'h07;
            wr(8'h04, i < 2 ? 32'h4 : 32'he, 2'b00);
            frm();
            chk(r32[2], i[0]);
        end
        mn  <= 6'h06;
        brk <= 1'b1;
        wr(8'h04, 32'h0, 2'b00);
        frm();
        chk(r32[1], 1'b1);
        brk <= 1'b0;
        $display("test checks done");
        mw <= 32'h35;
        wr(8'h00, 32'h0423, 2'b00);
        frm();
        rdc(8'h10, 32'h2);
        rdc(8'h0c, 32'h6);
        wr(8'h00, 32'h0425, 2'b00);
        frm();
        rdc(8'h10, 32'h0);
        wr(8'h08, 32'h2, 2'b00);
        frm();
        chk(gap, 2 * PC);
        chk(irq, 1'b0);
        wr(8'h18, 32'h1, 2'b00);
        chk(irq, 1'b1);
        wr(8'h00, 32'h0424, 2'b00);
        wr(8'h14, 32'hf, 2'b00);
        chk(irq, 1'b0);
        $display("test period and interrupt done");
        finish_test();
    end
endmodule : ssi_encoder_cyclic_master_test
`default_nettype wire
